// ---- rtl/aeim_defines.svh ----
`ifndef AEIM_DEFINES_SVH
`define AEIM_DEFINES_SVH

// ==========================================
// Register offsets
`define AEIM_REG_CFG        4'h0
`define AEIM_REG_DO_WIRED   4'h1
`define AEIM_REG_STATUS     4'h2
`define AEIM_REG_IRQ_CLR    4'h3
`define AEIM_REG_IRQ_EN     4'h4
`define AEIM_REG_ERRNUM     4'h5
`define AEIM_REG_REV_CNT    4'h6
`define AEIM_REG_CTRL       4'h7

// ==========================================
// Config fields
`define AEIM_CFG_ENC_LSB    0
`define AEIM_CFG_COORD_LSB  4
`define AEIM_CFG_STOPSEL    6
`define AEIM_CFG_RESET      16'h0000

// ==========================================
// Status bits
`define AEIM_ST_ZM_ERR      0
`define AEIM_ST_RED_ERR     1
`define AEIM_ST_WIREBREAK   2
`define AEIM_ST_EXT_START   3
`define AEIM_ST_EXT_STOP    4
`define AEIM_ST_WIDTH       5

// ==========================================
// Error numbers and limits
`define AEIM_ERR_ZERO_MARK  8'h0B
`define AEIM_ERR_RED_SW     8'h12
`define AEIM_ZM_TOL         4
`define AEIM_CUR_MIN_UA     6000
`define AEIM_RED_MIN_MS     24
`define AEIM_CLK_KHZ        40000
`define AEIM_RED_MIN_CYC    (`AEIM_RED_MIN_MS * `AEIM_CLK_KHZ)
`define AEIM_REV_RESET      16'h0010

`endif

// ---- rtl/aeim_pkg.sv ----
package aeim_pkg;
	typedef enum logic [3:0] {
		AEIM_ENC_INC_NOZM   = 4'h0,
		AEIM_ENC_INC_ZM     = 4'h1,
		AEIM_ENC_INC_ZM_MON = 4'h3,
		AEIM_ENC_SSI_GRAY   = 4'h2,
		AEIM_ENC_SSI_XGRAY  = 4'h6,
		AEIM_ENC_AXIS1      = 4'h7,
		AEIM_ENC_AXIS2      = 4'h5
	} aeim_enc_t;

	typedef enum logic [1:0] {
		AEIM_COORD_UNUSED = 2'h0,
		AEIM_COORD_LEVEL  = 2'h1,
		AEIM_COORD_EDGE   = 2'h3
	} aeim_coord_t;

	typedef enum logic [1:0] {
		AEIM_RS_IDLE  = 2'h0,
		AEIM_RS_ONSW  = 2'h1,
		AEIM_RS_LEFT  = 2'h3
	} aeim_rs_t;
endpackage

// ---- rtl/aeim_zero_mark_mon.sv ----
`timescale 1ns/1ps
`include "aeim_defines.svh"
module aeim_zero_mark_mon
	import aeim_pkg::*;
#(
	parameter int CW = 26
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          enable,
	input  wire logic          count_en,
	input  wire logic          count_up,
	input  wire logic          zero_mark,
	input  wire logic [CW-1:0] rev_counts,
	output logic               trip
);
	logic signed [CW+1:0] net;
	logic [CW+1:0]        travel;
	logic                 reversed;
	logic                 last_dir;
	logic                 seen;

	function automatic logic [CW+1:0] mag(input logic signed [CW+1:0] v);
		mag = v[CW+1] ? (CW+2)'(-v) : v;
	endfunction

	logic [CW+1:0] rev_w;
	logic [CW+1:0] net_mag;
	logic          spacing_bad;
	logic          overrun;
	assign rev_w       = (CW+2)'(rev_counts);
	assign net_mag     = mag(net);
	// ==========================================
	// Spacing checks
	assign spacing_bad = reversed
		? (net_mag > (CW+2)'(`AEIM_ZM_TOL))
		: ((net_mag + (CW+2)'(`AEIM_ZM_TOL) < rev_w) ||
		   (net_mag > rev_w + (CW+2)'(`AEIM_ZM_TOL)));
	// Missing mark: travel since last mark beyond one turn plus tolerance
	assign overrun = travel > rev_w + (CW+2)'(`AEIM_ZM_TOL);

	always_ff @(posedge clk) begin
		if (!resetn || !enable) begin
			net      <= '0;
			travel   <= '0;
			reversed <= 1'b0;
			last_dir <= 1'b1;
			seen     <= 1'b0;
		end else if (zero_mark) begin
			net      <= '0;
			travel   <= '0;
			reversed <= 1'b0;
			seen     <= 1'b1;
		end else if (count_en) begin
			net      <= count_up ? net + 1'b1 : net - 1'b1;
			if (!overrun)
				travel <= travel + 1'b1;
			if (count_up != last_dir)
				reversed <= 1'b1;
			last_dir <= count_up;
		end
	end

	// First mark only arms the spacing check
	assign trip = enable && ((zero_mark && seen && spacing_bad) || overrun);

	a_trip_gated: assert property (@(posedge clk) disable iff (!resetn)
		trip |-> enable)
		else $error("zero mark trip while disabled");
endmodule

// ---- rtl/aeim_red_switch_mon.sv ----
`timescale 1ns/1ps
`include "aeim_defines.svh"
module aeim_red_switch_mon
	import aeim_pkg::*;
#(
	parameter int MIN_CYC = `AEIM_RED_MIN_CYC,
	parameter int CW      = 26
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          enable,
	input  wire logic          ref_active,
	input  wire logic          red_switch,
	input  wire logic          zero_mark,
	input  wire logic          count_en,
	input  wire logic [CW-1:0] rev_counts,
	output logic               trip
);
	aeim_rs_t      state;
	logic [31:0]   timer;
	logic [CW:0]   on_travel;
	logic          long_on;
	logic          red_q;

	assign long_on = on_travel > {1'b0, rev_counts};
	// ==========================================
	// Timer from last zero mark or switch end
	always_ff @(posedge clk) begin
		if (!resetn || !enable)
			timer <= '0;
		else if (zero_mark || (red_q && !red_switch))
			timer <= '0;
		else if (timer != 32'hFFFF_FFFF)
			timer <= timer + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			red_q <= 1'b0;
		else
			red_q <= red_switch;
	end

	always_ff @(posedge clk) begin
		if (!resetn || !enable) begin
			state     <= AEIM_RS_IDLE;
			on_travel <= '0;
		end else begin
			case (state)
				AEIM_RS_IDLE: begin
					on_travel <= '0;
					if (ref_active && red_switch)
						state <= AEIM_RS_ONSW;
				end
				AEIM_RS_ONSW: begin
					if (count_en && !long_on)
						on_travel <= on_travel + 1'b1;
					if (!red_switch)
						state <= long_on ? AEIM_RS_LEFT : AEIM_RS_IDLE;
				end
				AEIM_RS_LEFT: begin
					if (zero_mark || !ref_active)
						state <= AEIM_RS_IDLE;
				end
				default: state <= AEIM_RS_IDLE;
			endcase
		end
	end

	// Mark too soon after switch end, or switch end too soon after mark
	assign trip = enable && (
		(state == AEIM_RS_LEFT && zero_mark && timer < 32'(MIN_CYC)) ||
		(state == AEIM_RS_ONSW && !red_switch && long_on &&
		 timer < 32'(MIN_CYC)));

	a_rs_qualified: assert property (@(posedge clk) disable iff (!resetn)
		trip |-> enable && state != AEIM_RS_IDLE)
		else $error("reduction trip without qualified pass");
endmodule

// ---- rtl/aeim_top.sv ----
// Notes on behaviour
// - Wired, switched-on output with current below 6 mA flags wirebreak.
// - Outputs reset to not wired; no wirebreak until configured wired.
// - Coordination input acts only while positioning function runs.
// - External start: input high (level) or rising edge (edge mode).
// - External stop: input low (level) or rising edge (edge mode).
// - Coordination mode level, edge or unused; unused is default.
// - Encoder type: incremental variants, SSI Gray/excess Gray, borrowed axis.
// - Zero-mark and reduction monitors only for monitored incremental type.
// - No reversal: zero-mark spacing is one revolution within 4 counts.
// - With reversal: net count between marks is zero within 4 counts.
// - Missing mark or bad spacing reports external error 11.
// - At least 24 ms travel between zero mark and reduction switch end.
// - Reduction check only after more than one revolution on the switch.
// - Reduction adjustment failure reports external error 18.
`timescale 1ns/1ps
`include "aeim_defines.svh"
module aeim_top
	import aeim_pkg::*;
#(
	parameter int N_DO    = 4,
	parameter int CW      = 26,
	parameter int MIN_CYC = `AEIM_RED_MIN_CYC
) (
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic [3:0]      addr,
	input  wire logic [15:0]     wdata,
	input  wire logic            wr,
	input  wire logic            rd,
	output logic [15:0]          rdata,
	output logic                 irq,
	input  wire logic [N_DO-1:0] do_on,
	input  wire logic [N_DO-1:0] do_current_low,
	input  wire logic            coordination_input,
	input  wire logic            positioning_active,
	input  wire logic            ref_active,
	input  wire logic            red_switch,
	input  wire logic            zero_mark,
	input  wire logic            count_en,
	input  wire logic            count_up,
	output logic                 ext_start,
	output logic                 ext_stop,
	output logic [N_DO-1:0]      wirebreak
);
	// ==========================================
	// Registers
	logic [15:0]              cfg;
	logic [N_DO-1:0]          do_wired;
	logic [`AEIM_ST_WIDTH-1:0] status;
	logic [`AEIM_ST_WIDTH-1:0] irq_en;
	logic [7:0]               err_num;
	logic [CW-1:0]            rev_counts;
	logic [N_DO-1:0]          wb_latch;
	logic                     coord_q;
	logic                     zm_trip;
	logic                     rs_trip;
	logic                     mon_en;
	logic                     coord_rise;
	logic                     next_start;
	logic                     next_stop;
	logic [N_DO-1:0]          wb_now;
	logic [`AEIM_ST_WIDTH-1:0] events;
	aeim_enc_t                enc;
	aeim_coord_t              coord_mode;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic s);
		hit = s && (a == off);
	endfunction

	assign enc        = aeim_enc_t'(cfg[`AEIM_CFG_ENC_LSB +: 4]);
	assign coord_mode = aeim_coord_t'(cfg[`AEIM_CFG_COORD_LSB +: 2]);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg        <= `AEIM_CFG_RESET;
			do_wired   <= '0;
			irq_en     <= '0;
			rev_counts <= CW'(`AEIM_REV_RESET);
		end else if (wr) begin
			if (hit(addr, `AEIM_REG_CFG, 1'b1))
				cfg <= wdata;
			if (hit(addr, `AEIM_REG_DO_WIRED, 1'b1))
				do_wired <= wdata[N_DO-1:0];
			if (hit(addr, `AEIM_REG_IRQ_EN, 1'b1))
				irq_en <= wdata[`AEIM_ST_WIDTH-1:0];
			if (hit(addr, `AEIM_REG_REV_CNT, 1'b1))
				rev_counts <= CW'(wdata);
		end
	end

	// ==========================================
	// Wirebreak detection
	// Current detector reports the below-6 mA comparison as a level
	assign wb_now = do_wired & do_on & do_current_low;

	// ==========================================
	// Coordination input
	always_ff @(posedge clk) begin
		if (!resetn)
			coord_q <= 1'b0;
		else
			coord_q <= coordination_input;
	end
	assign coord_rise = coordination_input && !coord_q;

	always_comb begin
		next_start = 1'b0;
		next_stop  = 1'b0;
		if (positioning_active) begin
			case (coord_mode)
				AEIM_COORD_LEVEL: begin
					if (cfg[`AEIM_CFG_STOPSEL])
						next_stop = !coordination_input;
					else
						next_start = coordination_input;
				end
				AEIM_COORD_EDGE: begin
					if (cfg[`AEIM_CFG_STOPSEL])
						next_stop = coord_rise;
					else
						next_start = coord_rise;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext_start <= 1'b0;
			ext_stop  <= 1'b0;
		end else begin
			ext_start <= next_start;
			ext_stop  <= next_stop;
		end
	end

	// ==========================================
	// Encoder monitors
	assign mon_en = (enc == AEIM_ENC_INC_ZM_MON);

	aeim_zero_mark_mon #(.CW(CW)) aeim_zero_mark_mon_inst (
		.clk        (clk),
		.resetn     (resetn),
		.enable     (mon_en),
		.count_en   (count_en),
		.count_up   (count_up),
		.zero_mark  (zero_mark),
		.rev_counts (rev_counts),
		.trip       (zm_trip)
	);

	aeim_red_switch_mon #(.MIN_CYC(MIN_CYC), .CW(CW)) aeim_red_switch_mon_inst (
		.clk        (clk),
		.resetn     (resetn),
		.enable     (mon_en),
		.ref_active (ref_active),
		.red_switch (red_switch),
		.zero_mark  (zero_mark),
		.count_en   (count_en),
		.rev_counts (rev_counts),
		.trip       (rs_trip)
	);

	// ==========================================
	// Sticky status, set wins over clear
	assign events = {next_stop, next_start, |wb_now, rs_trip, zm_trip};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status   <= '0;
			wb_latch <= '0;
		end else begin
			// Set beats clear so a fault in the clear cycle is kept
			status <= (status & ~(hit(addr, `AEIM_REG_IRQ_CLR, wr)
				? wdata[`AEIM_ST_WIDTH-1:0] : '0)) | events;
			wb_latch <= (wb_latch & ~((hit(addr, `AEIM_REG_IRQ_CLR, wr)
				&& wdata[`AEIM_ST_WIREBREAK]) ? {N_DO{1'b1}} : '0)) | wb_now;
		end
	end

	// Last error wins; 11 and 18 in the same cycle report 18
	always_ff @(posedge clk) begin
		if (!resetn)
			err_num <= 8'h00;
		else if (rs_trip)
			err_num <= `AEIM_ERR_RED_SW;
		else if (zm_trip)
			err_num <= `AEIM_ERR_ZERO_MARK;
		else if (hit(addr, `AEIM_REG_ERRNUM, wr))
			err_num <= 8'h00;
	end

	assign wirebreak = wb_latch;
	assign irq       = |(status & irq_en);

	// ==========================================
	// Read port
	always_ff @(posedge clk) begin
		if (!resetn)
			rdata <= '0;
		else if (rd) begin
			case (addr)
				`AEIM_REG_CFG:      rdata <= cfg;
				`AEIM_REG_DO_WIRED: rdata <= 16'(do_wired);
				`AEIM_REG_STATUS:   rdata <= 16'(status);
				`AEIM_REG_IRQ_EN:   rdata <= 16'(irq_en);
				`AEIM_REG_ERRNUM:   rdata <= 16'(err_num);
				`AEIM_REG_REV_CNT:  rdata <= rev_counts[15:0];
				`AEIM_REG_CTRL:     rdata <= 16'(wb_latch);
				default:            rdata <= 16'h0000;
			endcase
		end else
			rdata <= 16'h0000;
	end

	// ==========================================
	// Sequences
	sequence s_edge_start;
		positioning_active && coord_mode == AEIM_COORD_EDGE
		&& !cfg[`AEIM_CFG_STOPSEL] && $rose(coordination_input);
	endsequence
	sequence s_edge_stop;
		positioning_active && coord_mode == AEIM_COORD_EDGE
		&& cfg[`AEIM_CFG_STOPSEL] && $rose(coordination_input);
	endsequence
	// Edge mode answers once per rise, never holds
	sequence s_start_pulse;
		ext_start ##1 !ext_start;
	endsequence
	sequence s_stop_pulse;
		ext_stop ##1 !ext_stop;
	endsequence

	// ==========================================
	// Checks
	a_wb_unwired: assert property (@(posedge clk) disable iff (!resetn)
		(wirebreak & ~$past(wirebreak) & ~$past(do_wired)) == '0)
		else $error("wirebreak on unwired output");
	a_wb_latch: assert property (@(posedge clk) disable iff (!resetn)
		|(do_wired & do_on & do_current_low) |=> |wirebreak)
		else $error("wirebreak not latched");
	a_wb_status: assert property (@(posedge clk) disable iff (!resetn)
		|(do_wired & do_on & do_current_low) |=> status[`AEIM_ST_WIREBREAK])
		else $error("wirebreak status not set");
	a_wb_sticky: assert property (@(posedge clk) disable iff (!resetn)
		!(wr && addr == `AEIM_REG_IRQ_CLR && wdata[`AEIM_ST_WIREBREAK])
		|=> (wirebreak & $past(wirebreak)) == $past(wirebreak))
		else $error("wirebreak dropped without clear");
	a_coord_idle: assert property (@(posedge clk) disable iff (!resetn)
		!positioning_active |=> !ext_start && !ext_stop)
		else $error("coordination acted outside positioning");
	a_coord_level: assert property (@(posedge clk) disable iff (!resetn)
		positioning_active && coord_mode == AEIM_COORD_LEVEL
		&& !cfg[`AEIM_CFG_STOPSEL] && coordination_input |=> ext_start)
		else $error("level start missed");
	a_level_stop: assert property (@(posedge clk) disable iff (!resetn)
		positioning_active && coord_mode == AEIM_COORD_LEVEL
		&& cfg[`AEIM_CFG_STOPSEL] && !coordination_input |=> ext_stop)
		else $error("level stop missed");
	a_coord_edge: assert property (@(posedge clk) disable iff (!resetn)
		s_edge_start |=> s_start_pulse)
		else $error("edge start not a single pulse");
	a_coord_stop: assert property (@(posedge clk) disable iff (!resetn)
		s_edge_stop |=> s_stop_pulse)
		else $error("edge stop not a single pulse");
	// Only a start-configured level or edge mode may raise a start
	a_start_cause: assert property (@(posedge clk) disable iff (!resetn)
		ext_start |-> $past(positioning_active) && !$past(cfg[`AEIM_CFG_STOPSEL])
		&& ($past(coord_mode) == AEIM_COORD_LEVEL
		|| $past(coord_mode) == AEIM_COORD_EDGE))
		else $error("start raised without cause");
	a_stop_cause: assert property (@(posedge clk) disable iff (!resetn)
		ext_stop |-> $past(positioning_active) && $past(cfg[`AEIM_CFG_STOPSEL])
		&& ($past(coord_mode) == AEIM_COORD_LEVEL
		|| $past(coord_mode) == AEIM_COORD_EDGE))
		else $error("stop raised without cause");
	a_coord_unused: assert property (@(posedge clk) disable iff (!resetn)
		coord_mode == AEIM_COORD_UNUSED |=> !ext_start && !ext_stop)
		else $error("unused input acted");
	a_err_eleven: assert property (@(posedge clk) disable iff (!resetn)
		zm_trip && !rs_trip |=> err_num == `AEIM_ERR_ZERO_MARK && status[`AEIM_ST_ZM_ERR])
		else $error("zero mark error not reported");
	a_err_eighteen: assert property (@(posedge clk) disable iff (!resetn)
		rs_trip |=> err_num == `AEIM_ERR_RED_SW && status[`AEIM_ST_RED_ERR])
		else $error("reduction error not reported");
	a_err_held: assert property (@(posedge clk) disable iff (!resetn)
		err_num != 8'h00 && !(wr && addr == `AEIM_REG_ERRNUM) |=> err_num != 8'h00)
		else $error("error number lost");
	a_mon_off: assert property (@(posedge clk) disable iff (!resetn)
		!mon_en |-> !zm_trip && !rs_trip)
		else $error("monitor active on wrong encoder");
	a_sticky_hold: assert property (@(posedge clk) disable iff (!resetn)
		status[`AEIM_ST_ZM_ERR] && !(wr && addr == `AEIM_REG_IRQ_CLR)
		|=> status[`AEIM_ST_ZM_ERR])
		else $error("sticky error lost");
	a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
		!(wr && addr == `AEIM_REG_IRQ_CLR) |=> (status & $past(status)) == $past(status))
		else $error("status bit dropped without clear");
	a_clear_takes: assert property (@(posedge clk) disable iff (!resetn)
		wr && addr == `AEIM_REG_IRQ_CLR && wdata[`AEIM_ST_ZM_ERR] && !zm_trip
		|=> !status[`AEIM_ST_ZM_ERR])
		else $error("status clear ignored");
	a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!rd |=> rdata == 16'h0000)
		else $error("read data outside read cycle");
endmodule

// ---- tb/aeim_encoder_model.sv ----
`timescale 1ns/1ps
module aeim_encoder_model #(
	parameter int REV = 16
) (
	input  wire logic clk,
	output logic      zero_mark,
	output logic      count_en,
	output logic      count_up,
	output logic      red_switch
);
	// ==========================================
	// Position, one counter pulse every two cycles
	int pos = 0;
	initial begin
		zero_mark = 1'b0;
		count_en = 1'b0;
		count_up = 1'b1;
		red_switch = 1'b0;
	end
	task automatic step(input bit up);
		@(posedge clk);
		pos = up ? pos + 1 : pos - 1;
		count_en <= 1'b1;
		count_up <= up;
		zero_mark <= (pos % REV == 0); // Mark only on revolution boundary
		@(posedge clk);
		count_en <= 1'b0;
		zero_mark <= 1'b0;
	endtask
	task automatic move(input int n, input bit up);
		repeat (n) step(up);
	endtask
	task automatic to_mark();
		do step(1'b1); while (pos % REV != 0);
	endtask
	// Commanded fault only: a mark off the revolution boundary
	task automatic stray_mark();
		@(posedge clk);
		zero_mark <= 1'b1;
		@(posedge clk);
		zero_mark <= 1'b0;
	endtask
	task automatic set_switch(input bit v);
		@(posedge clk);
		red_switch <= v;
	endtask
endmodule

// ---- tb/axis_encoder_io_monitor_tb.sv ----
`timescale 1ns/1ps
module axis_encoder_io_monitor_tb
	import aeim_pkg::*;
;
	logic        clk;
	logic        resetn;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        irq;
	logic [3:0]  do_on;
	logic [3:0]  do_current_low;
	logic        coordination_input;
	logic        positioning_active;
	logic        ref_active;
	logic        red_switch;
	logic        zero_mark;
	logic        count_en;
	logic        count_up;
	logic        ext_start;
	logic        ext_stop;
	logic [3:0]  wirebreak;
	int          fails = 0;
	int          total_checks = 0;
	logic [3:0]  enc_codes [7] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h6, 4'h7, 4'h5};

	// ==========================================
	// Design and far side
	aeim_top #(.MIN_CYC(50)) aeim_top_inst (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .do_on(do_on), .do_current_low(do_current_low),
		.coordination_input(coordination_input), .positioning_active(positioning_active),
		.ref_active(ref_active), .red_switch(red_switch), .zero_mark(zero_mark),
		.count_en(count_en), .count_up(count_up), .ext_start(ext_start),
		.ext_stop(ext_stop), .wirebreak(wirebreak)
	);
	aeim_encoder_model aeim_encoder_model_inst (
		.clk(clk), .zero_mark(zero_mark), .count_en(count_en), .count_up(count_up),
		.red_switch(red_switch)
	);

	// ==========================================
	// Tasks
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic expect_reg(input logic [3:0] a, input logic [15:0] exp, input string name);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(name, rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic coord(input logic [15:0] c, input logic pa, input logic c0, input logic c1,
		input logic es, input logic et, input logic pulse);
		wr_reg(4'h0, c);
		positioning_active <= pa;
		coordination_input <= c0;
		repeat (3) @(posedge clk);
		coordination_input <= c1;
		settle(1);
		check("ext_start", 16'(ext_start), 16'(es));
		check("ext_stop", 16'(ext_stop), 16'(et));
		if (pulse) begin
			settle(1);
			check("ext_start pulse", 16'(ext_start), 16'h0000);
			check("ext_stop pulse", 16'(ext_stop), 16'h0000);
		end
	endtask

	// ==========================================
	// Clock, watchdog, tests
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		finish_test();
	end
	initial begin
		resetn = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		do_on = 4'h0;
		do_current_low = 4'h0;
		coordination_input = 1'b0;
		positioning_active = 1'b0;
		ref_active = 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		expect_reg(4'h0, 16'h0000, "cfg");
		expect_reg(4'h1, 16'h0000, "do_wired");
		expect_reg(4'h6, 16'h0010, "rev_counts");
		expect_reg(4'hF, 16'h0000, "unmapped");
		foreach (enc_codes[i]) begin
			wr_reg(4'h0, 16'(enc_codes[i]));
			expect_reg(4'h0, 16'(enc_codes[i]), "enc type");
		end
		// Off or unwired outputs must not flag; only wired, switched-on outputs count
		do_on <= 4'h3;
		do_current_low <= 4'h7;
		settle(3);
		check("wirebreak unwired", 16'(wirebreak), 16'h0000);
		wr_reg(4'h1, 16'h0005);
		settle(2);
		check("wirebreak", 16'(wirebreak), 16'h0001);
		do_current_low <= 4'h0;
		settle(3);
		check("wirebreak latched", 16'(wirebreak), 16'h0001);
		wr_reg(4'h2, 16'hFFFF);
		expect_reg(4'h2, 16'h0004, "status");
		expect_reg(4'h7, 16'h0001, "wirebreak reg");
		wr_reg(4'h4, 16'h0004);
		settle(0);
		check("irq", 16'(irq), 16'h0001);
		wr_reg(4'h4, 16'h0000);
		settle(0);
		check("irq masked", 16'(irq), 16'h0000);
		wr_reg(4'h4, 16'h0004);
		wr_reg(4'h3, 16'h0004);
		settle(1);
		check("irq cleared", 16'(irq), 16'h0000);
		check("wirebreak cleared", 16'(wirebreak), 16'h0000);
		coord(16'h0000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		coord(16'h0020, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		coord(16'h0010, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		coord(16'h0010, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		coord(16'h0050, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		coord(16'h0030, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		coord(16'h0070, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
		positioning_active <= 1'b0;
		coordination_input <= 1'b0;
		// Unmonitored type ignores a misplaced mark
		wr_reg(4'h0, 16'h0001);
		wr_reg(4'h3, 16'h001F);
		aeim_encoder_model_inst.move(5, 1'b1);
		aeim_encoder_model_inst.stray_mark();
		expect_reg(4'h2, 16'h0000, "status unmonitored");
		wr_reg(4'h0, 16'h0003);
		aeim_encoder_model_inst.to_mark();
		aeim_encoder_model_inst.move(3, 1'b1);
		aeim_encoder_model_inst.move(3, 1'b0);
		expect_reg(4'h2, 16'h0000, "status reversal");
		// Keep going down so the next pass has no reversal
		aeim_encoder_model_inst.move(16, 1'b0);
		expect_reg(4'h2, 16'h0000, "status one rev");
		aeim_encoder_model_inst.move(6, 1'b0);
		aeim_encoder_model_inst.stray_mark();
		settle(2);
		expect_reg(4'h2, 16'h0001, "status spacing");
		expect_reg(4'h5, 16'h000B, "err number");
		// Next real mark is short too; one more revolution realigns
		aeim_encoder_model_inst.to_mark();
		aeim_encoder_model_inst.move(16, 1'b1);
		expect_reg(4'h5, 16'h000B, "err number latched");
		wr_reg(4'h3, 16'h001F);
		wr_reg(4'h5, 16'h0000);
		expect_reg(4'h2, 16'h0000, "status cleared");
		ref_active <= 1'b1;
		aeim_encoder_model_inst.set_switch(1'b1);
		aeim_encoder_model_inst.move(4, 1'b1);
		aeim_encoder_model_inst.set_switch(1'b0);
		settle(4);
		expect_reg(4'h2, 16'h0000, "status short switch");
		aeim_encoder_model_inst.set_switch(1'b1);
		aeim_encoder_model_inst.move(20, 1'b1);
		aeim_encoder_model_inst.to_mark();
		aeim_encoder_model_inst.set_switch(1'b0);
		settle(4);
		expect_reg(4'h2, 16'h0002, "status reduction");
		expect_reg(4'h5, 16'h0012, "err number red");
		// Shorter turn than the mark spacing: travel overruns before the mark
		ref_active <= 1'b0;
		wr_reg(4'h3, 16'h001F);
		wr_reg(4'h5, 16'h0000);
		wr_reg(4'h6, 16'h0008);
		aeim_encoder_model_inst.move(16, 1'b1);
		expect_reg(4'h2, 16'h0001, "status overrun");
		expect_reg(4'h5, 16'h000B, "err number overrun");
		finish_test();
	end
endmodule
